// File: core/sps_pkg.sv
// shared constants and types of the serial shift / parallel store block
// assumes one 20 MHz reference clock and a synchronous active-high reset

package sps_pkg;

   // ----------------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------------
   localparam int unsigned DATA_W      = 16;
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned CLK_FREQ_HZ = 20_000_000;
   localparam int unsigned CLK_PER_PS  = 1_000_000_000 / (CLK_FREQ_HZ / 1000);

   // ----------------------------------------------------------------------
   // pin carrier: everything the controller drives toward the block
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic dir;
      logic shift_clock_n;
      logic store_clock;
      logic store_clear_n;
      logic sio_in;
   } sps_pins_t;

   localparam int unsigned PINS_W = $bits(sps_pins_t);

   // idle values: no shift fall and no store rise can come out of reset
   localparam sps_pins_t PINS_RST = '{
      cs_n          : 1'h1,
      dir           : 1'h0,
      shift_clock_n : 1'h0,
      store_clock   : 1'h1,
      store_clear_n : 1'h1,
      sio_in        : 1'h0
   };

   localparam logic [DATA_W-1:0] STORE_RST = 16'h0000;
   localparam logic [DATA_W-1:0] SHIFT_RST = 16'h0000;

   // ----------------------------------------------------------------------
   // shift register operating modes
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      SPS_HOLD     = 4'h1,
      SPS_SER_IN   = 4'h2,
      SPS_SER_OUT  = 4'h4,
      SPS_PAR_LOAD = 4'h8
   } sps_mode_t;

endpackage

// File: core/sps_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous pins; output changes once stages two and three agree

`timescale 1ns/1ps

module sps_sync #(
   parameter int unsigned          W       = 1,
   parameter logic        [W-1:0]  RST_VAL = '0
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // pins in, settled value out
   input  wire logic [W-1:0]  din,
   output      logic [W-1:0]  dout_q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree_d;

   // ----------------------------------------------------------------------
   // chain; first stage feeds only the second
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------------------------------------
   // agreement, bit by bit
   // ----------------------------------------------------------------------
   // a lone disagreeing sample is held off, so one pin edge counts once
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_agree
         assign agree_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout_q[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= RST_VAL;
      end else begin
         dout_q <= agree_d;
      end
   end

endmodule // sps_sync

// File: core/sps_store.sv
// 16-bit storage register with asynchronous clear
// assumes load is a one-cycle pulse on clk; clear_n comes straight from the pin

`timescale 1ns/1ps

module sps_store #(
   parameter int unsigned W = sps_pkg::DATA_W
) (
   // clock and resets
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          clear_n,
   // load request and data
   input  wire logic          load,
   input  wire logic [W-1:0]  din,
   output      logic [W-1:0]  dout_q
);

   // ----------------------------------------------------------------------
   // storage; clear acts at once, only release waits for the clock
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge clear_n) begin
      if (!clear_n) begin
         dout_q <= '0;
      end else if (rst) begin
         dout_q <= W'(sps_pkg::STORE_RST);
      end else if (load) begin
         dout_q <= din;
      end
   end

endmodule // sps_store

// File: core/sps_shift_store.sv
// top of the serial shift register with parallel-out storage register
// assumes the controller pins are asynchronous to REF_CLK and change far slower than it

`timescale 1ns/1ps

module sps_shift_store #(
   parameter int unsigned DATA_W = sps_pkg::DATA_W
) (
   // clock and reset
   input  wire logic               REF_CLK,
   input  wire logic               RST,
   // controller selects
   input  wire logic               CS_N,
   input  wire logic               DIR,
   // controller clocks and clear
   input  wire logic               SHIFT_CLOCK_N,
   input  wire logic               STORE_CLOCK,
   input  wire logic               STORE_CLEAR_N,
   // shared serial pin
   input  wire logic               SIO_I,
   output      logic               SIO_O,
   output      logic               SIO_OE,
   // parallel outputs
   output      logic [DATA_W-1:0]  PARALLEL_OUTPUTS
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   sps_pkg::sps_pins_t   pins_raw;
   sps_pkg::sps_pins_t   pins_v;
   sps_pkg::sps_pins_t   pins_p_q;
   sps_pkg::sps_mode_t   mode_d;
   logic [DATA_W-1:0]    sh_q;
   logic [DATA_W-1:0]    sh_d;
   logic [DATA_W-1:0]    store_q;
   logic                 shift_fall;
   logic                 store_rise;
   logic                 store_load;
   logic                 sio_o_q;
   logic                 sio_oe_q;

   assign pins_raw = '{
      cs_n          : CS_N,
      dir           : DIR,
      shift_clock_n : SHIFT_CLOCK_N,
      store_clock   : STORE_CLOCK,
      store_clear_n : STORE_CLEAR_N,
      sio_in        : SIO_I
   };

   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   sps_sync #(
      .W       (sps_pkg::PINS_W),
      .RST_VAL (sps_pkg::PINS_RST)
   ) u_sync (
      .clk    (REF_CLK),
      .rst    (RST),
      .din    (pins_raw),
      .dout_q (pins_v)
   );

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pins_p_q <= sps_pkg::PINS_RST;
      end else begin
         pins_p_q <= pins_v;
      end
   end

   // ----------------------------------------------------------------------
   // clock edge detection on the settled pins
   // ----------------------------------------------------------------------
   // both edges are masked by chip select, so a stray clock edge while idle is lost
   assign shift_fall = pins_p_q.shift_clock_n & ~pins_v.shift_clock_n & ~pins_v.cs_n;
   assign store_rise = ~pins_p_q.store_clock & pins_v.store_clock & ~pins_v.cs_n;

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   always_comb begin
      if (pins_v.cs_n) begin
         mode_d = sps_pkg::SPS_HOLD;
      end else if (!pins_v.dir) begin
         mode_d = sps_pkg::SPS_SER_IN;
      end else if (pins_v.store_clock) begin
         mode_d = sps_pkg::SPS_PAR_LOAD;
      end else begin
         mode_d = sps_pkg::SPS_SER_OUT;
      end
   end

   // ----------------------------------------------------------------------
   // shift register next value
   // ----------------------------------------------------------------------
   always_comb begin
      sh_d = sh_q;
      if (shift_fall) begin
         case (mode_d)
            sps_pkg::SPS_SER_IN: begin
               sh_d = {sh_q[DATA_W-2:0], pins_v.sio_in};
            end
            sps_pkg::SPS_SER_OUT: begin
               sh_d = {sh_q[DATA_W-2:0], sh_q[DATA_W-1]};
            end
            sps_pkg::SPS_PAR_LOAD: begin
               sh_d = store_q;
            end
            default: begin
               sh_d = sh_q;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sh_q <= DATA_W'(sps_pkg::SHIFT_RST);
      end else begin
         sh_q <= sh_d;
      end
   end

   // ----------------------------------------------------------------------
   // serial pin driver
   // ----------------------------------------------------------------------
   // driven from the next value so the pin shows bit 15 on the cycle it lands
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sio_o_q  <= 1'h0;
         sio_oe_q <= 1'h0;
      end else begin
         sio_o_q  <= sh_d[DATA_W-1];
         sio_oe_q <= ~pins_v.cs_n & pins_v.dir;
      end
   end

   // ----------------------------------------------------------------------
   // storage register
   // ----------------------------------------------------------------------
   // load waits for the settled clear so a freshly released clear cannot race
   assign store_load = store_rise & ~pins_v.dir & pins_v.store_clear_n;

   sps_store #(
      .W (DATA_W)
   ) u_store (
      .clk     (REF_CLK),
      .rst     (RST),
      .clear_n (STORE_CLEAR_N),
      .load    (store_load),
      .din     (sh_q),
      .dout_q  (store_q)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign SIO_O            = sio_o_q;
   assign SIO_OE           = sio_oe_q;
   assign PARALLEL_OUTPUTS = store_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   // ----------------------------------------------------------------------
   // shift register checks
   // ----------------------------------------------------------------------
   chk_rise_no_shift: assert property (
      pins_v.shift_clock_n && !pins_p_q.shift_clock_n |=> $stable(sh_q))
      else $error("shift register moved on a rising shift clock");

   chk_idle_no_edge: assert property (
      pins_v.cs_n |-> !shift_fall && !store_load)
      else $error("clock edge taken while deselected");

   chk_in_first_pos: assert property (
      shift_fall && !pins_v.dir |=> sh_q[0] == $past(pins_v.sio_in))
      else $error("serial input did not enter the first position");

   chk_idle_shift_hold: assert property (
      pins_v.cs_n |=> $stable(sh_q))
      else $error("shift register moved while deselected");

   chk_idle_pin_float: assert property (
      pins_v.cs_n |=> !SIO_OE)
      else $error("serial pin driven while deselected");

   chk_shift_fall_only: assert property (
      !shift_fall |=> $stable(sh_q))
      else $error("shift register moved without falling shift clock");

   chk_serial_in_shift: assert property (
      shift_fall && !pins_v.dir
      |=> sh_q == {$past(sh_q[DATA_W-2:0]), $past(pins_v.sio_in)})
      else $error("serial input bit not shifted into bit 0");

   chk_serial_out_rotate: assert property (
      shift_fall && pins_v.dir && !pins_v.store_clock
      |=> sh_q == {$past(sh_q[DATA_W-2:0]), $past(sh_q[DATA_W-1])})
      else $error("serial output did not rotate contents");

   chk_out_pin_data: assert property (
      !pins_v.cs_n && pins_v.dir |=> SIO_OE && (SIO_O == sh_q[DATA_W-1]))
      else $error("serial pin not driving bit 15");

   // ----------------------------------------------------------------------
   // serial pin checks
   // ----------------------------------------------------------------------
   // pin is looked at one cycle on, since its driver is a flop
   chk_in_pin_float: assert property (
      !pins_v.dir |=> !SIO_OE)
      else $error("serial pin driven while in input mode");

   chk_out_order: assert property (
      shift_fall && pins_v.dir && !pins_v.store_clock
      |=> SIO_O == $past(sh_q[DATA_W-2]))
      else $error("serial output not taken from the last position");

   chk_out_recirc: assert property (
      shift_fall && pins_v.dir && !pins_v.store_clock
      |=> sh_q[0] == $past(SIO_O))
      else $error("driven bit did not re-enter the first position");

   chk_load_no_shift: assert property (
      shift_fall && pins_v.dir && pins_v.store_clock
      |=> SIO_O == $past(store_q[DATA_W-1]))
      else $error("serial shift seen during load from storage");

   chk_par_load_copy: assert property (
      shift_fall && pins_v.dir && pins_v.store_clock |=> sh_q == $past(store_q))
      else $error("shift register not loaded from storage");

   // ----------------------------------------------------------------------
   // storage register checks
   // ----------------------------------------------------------------------
   // clear is sampled raw here, so a clear pulse shorter than a cycle escapes
   chk_store_rise_only: assert property (
      !store_rise && STORE_CLEAR_N ##1 STORE_CLEAR_N |-> $stable(store_q))
      else $error("storage changed without a rising store clock");

   chk_clear_no_load: assert property (
      !pins_v.store_clear_n |-> !store_load)
      else $error("storage load taken while clear low");

   chk_dir_no_load: assert property (
      pins_v.dir |-> !store_load)
      else $error("storage load taken with direction high");

   chk_clear_zero: assert property (
      !STORE_CLEAR_N |-> PARALLEL_OUTPUTS == '0)
      else $error("storage not cleared while clear low");

   chk_store_hold: assert property (
      (pins_v.cs_n || pins_v.dir) && STORE_CLEAR_N ##1 STORE_CLEAR_N
      |-> $stable(store_q))
      else $error("storage changed while held");

   chk_store_load: assert property (
      store_rise && !pins_v.dir && pins_v.store_clear_n && STORE_CLEAR_N
      ##1 STORE_CLEAR_N |-> store_q == $past(sh_q))
      else $error("storage not loaded from shift register");

   // ----------------------------------------------------------------------
   // coverage of the main scenarios
   // ----------------------------------------------------------------------
   cov_idle_fall: cover property (
      pins_v.cs_n && pins_p_q.shift_clock_n && !pins_v.shift_clock_n);

   cov_serial_in: cover property (
      shift_fall && mode_d == sps_pkg::SPS_SER_IN);

   cov_serial_out: cover property (
      shift_fall && mode_d == sps_pkg::SPS_SER_OUT);

   cov_par_load: cover property (
      shift_fall && mode_d == sps_pkg::SPS_PAR_LOAD);

   cov_store: cover property (
      store_load ##1 PARALLEL_OUTPUTS != '0);

endmodule // sps_shift_store

// File: testbench/sps_ctrl_model.sv
// controller-side model of the shared serial pin
// assumes the block drives the pin only while its output enable is high

`timescale 1ns/1ps

module sps_ctrl_model (
   // clock
   input  wire logic  clk,
   // block side of the pin
   input  wire logic  oe,
   input  wire logic  o,
   // controller side of the pin
   input  wire logic  drive,
   input  wire logic  data,
   // resolved pin level
   output      logic  sio
);
   // ----------------------------------------------------------------------
   // pin resolution
   // ----------------------------------------------------------------------
   logic last_q = 1'h0;

   // released pin has no pull: toggle so a floating read never looks valid
   always_comb begin
      if (oe) begin
         sio = o;
      end else if (drive) begin
         sio = data;
      end else begin
         sio = ~last_q;
      end
   end

   always_ff @(posedge clk) begin
      last_q <= sio;
   end
endmodule // sps_ctrl_model

// File: testbench/sps_shift_store_bench.sv
// self-checking bench of the serial shift / parallel store block
// assumes the block settles any pin change within six reference clock edges

`timescale 1ns/1ps

module sps_shift_store_bench;
   // ----------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------
   localparam logic [15:0] W1 = 16'hA5C3;
   localparam logic [15:0] W2 = 16'h5A3C;
   logic               ref_clk = 1'h0;
   logic               rst     = 1'h1;
   sps_pkg::sps_pins_t p       = sps_pkg::PINS_RST;
   logic               sio_o;
   logic               sio_oe;
   logic               sio;
   logic [15:0]        po;
   int                 miscompares = 0;
   int                 checks_done = 0;
   int                 n;

   always #25 ref_clk = ~ref_clk;

   sps_shift_store DUT (
      .REF_CLK(ref_clk), .RST(rst), .CS_N(p.cs_n), .DIR(p.dir),
      .SHIFT_CLOCK_N(p.shift_clock_n), .STORE_CLOCK(p.store_clock),
      .STORE_CLEAR_N(p.store_clear_n), .SIO_I(sio), .SIO_O(sio_o),
      .SIO_OE(sio_oe), .PARALLEL_OUTPUTS(po));

   sps_ctrl_model partner (
      .clk(ref_clk), .oe(sio_oe), .o(sio_o), .drive(~p.cs_n & ~p.dir),
      .data(p.sio_in), .sio(sio));

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic finish_test();
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // pins held far longer than the synchroniser needs
   task automatic go();
      repeat (6) @(posedge ref_clk);
      #2;
   endtask

   task automatic fall();
      p.shift_clock_n = 1'h1;
      go();
      p.shift_clock_n = 1'h0;
      go();
   endtask

   task automatic shin(input logic b);
      p.sio_in = b;
      fall();
   endtask

   task automatic st();
      p.store_clock = 1'h1;
      go();
      p.store_clock = 1'h0;
      go();
   endtask

   task automatic load_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) shin(w[i]);
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic serial_in_store();
      p.cs_n = 1'h0;
      go();
      check("oe serial in", {15'h0, sio_oe}, 16'h0000);
      load_word(W1);
      st();
      check("store after serial in", po, W1);
   endtask

   task automatic deselected_hold();
      p.cs_n = 1'h1;
      go();
      check("oe deselected", {15'h0, sio_oe}, 16'h0000);
      load_word(W2);
      st();
      check("store deselected", po, W1);
      p.cs_n = 1'h0;
      go();
      st();
      check("shift ignored deselected", po, W1);
   endtask

   task automatic serial_out();
      p.dir = 1'h1;
      n = 0;
      while (sio_oe !== 1'h1 && n < 10) begin
         @(posedge ref_clk);
         #2;
         n++;
      end
      if (sio_oe !== 1'h1) begin
         miscompares++;
         $display("Error serial pin enable expected 1 seen %b", sio_oe);
         finish_test();
      end
      go();
      check("oe serial out", {15'h0, sio_oe}, 16'h0001);
      check("first out bit", {15'h0, sio_o}, {15'h0, W1[15]});
      for (int i = 1; i <= 16; i++) begin
         fall();
         check("out bit", {15'h0, sio_o}, {15'h0, W1[(31 - i) % 16]});
      end
      p.dir = 1'h0;
      go();
      st();
      check("store after rotation", po, W1);
   endtask

   task automatic load_back();
      load_word(W2);
      p.dir = 1'h1;
      go();
      p.store_clock = 1'h1;
      go();
      check("store held dir high", po, W1);
      fall();
      check("bit after load", {15'h0, sio_o}, {15'h0, W1[15]});
      p.store_clock = 1'h0;
      go();
      fall();
      check("bit after load shift", {15'h0, sio_o}, {15'h0, W1[14]});
      p.dir = 1'h0;
      go();
      st();
      check("store after load", po, {W1[14:0], W1[15]});
   endtask

   task automatic clear_store();
      p.store_clear_n = 1'h0;
      #1;
      check("clear at once", po, 16'h0000);
      go();
      st();
      check("clear beats store", po, 16'h0000);
      p.store_clear_n = 1'h1;
      go();
      check("after clear", po, 16'h0000);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      #2;
      rst = 1'h0;
      go();
      check("store reset", po, 16'h0000);
      check("oe reset", {15'h0, sio_oe}, 16'h0000);
      p.store_clock = 1'h0;
      go();
      serial_in_store();
      deselected_hold();
      serial_out();
      load_back();
      clear_store();
      finish_test();
   end
endmodule // sps_shift_store_bench
